// [cto_pkg.sv]
package cto_pkg;

  // Register word indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h20;
  localparam logic [7:0] IDX_PRESCALE = 8'h26;
  localparam logic [7:0] IDX_DRIVE_CFG = 8'h28;
  localparam logic [7:0] IDX_ID_HIGH = 8'h2A;
  localparam logic [7:0] IDX_ID_LOW = 8'h2B;
  localparam logic [7:0] IDX_PAYLOAD_FIRST = 8'h2C;
  localparam logic [7:0] IDX_PAYLOAD_LAST = 8'h33;

  // Control register fields
  localparam int CTRL_RESET_REQ_POS = 0;
  localparam int CTRL_TX_REQ_POS = 1;
  localparam int CTRL_BUSY_POS = 2;
  localparam logic CTRL_RESET_REQ_RST = 1'h1;

  // Identifier low / remote / length register fields
  localparam int ID_LOW_POS = 5;
  localparam int RTR_POS = 4;
  localparam int DLC_W = 4;
  localparam int PRESCALE_W = 6;

  // Reset values of software-written registers
  localparam logic [7:0] REG_RST = 8'h00;

  // Frame layout: start, 11 id, remote, ext flag, reserved, 4 length bits
  localparam int ID_W = 11;
  localparam int FRAME_HDR_BITS = 19;
  localparam int PAYLOAD_BYTES = 8;
  localparam int FRAME_MAX_BITS = FRAME_HDR_BITS + 8 * PAYLOAD_BYTES;
  localparam logic [3:0] DLC_MAX = 4'h8;

  // Quanta per bit time
  localparam int BIT_QUANTA_DEFAULT = 8;

  typedef enum logic [1:0] {
    MODE_BIPHASE = 2'h0,
    MODE_UNUSED = 2'h1,
    MODE_NORMAL1 = 2'h2,
    MODE_NORMAL2 = 2'h3
  } cto_mode_t;

  typedef struct packed {
    logic highSideEn;
    logic lowSideEn;
    logic polarity;
  } cto_line_cfg_t;

  typedef struct packed {
    cto_line_cfg_t line1;
    cto_line_cfg_t line0;
    cto_mode_t driveMode;
  } cto_drive_cfg_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h1,
    TX_SEND = 2'h2
  } cto_tx_state_t;

endpackage : cto_pkg

// [cto_quantum_div.sv]
`timescale 1ns/100ps
module cto_quantum_div import cto_pkg::*; #(
  parameter int W = PRESCALE_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Divider setting and quantum enable
  input wire logic [W-1:0] divMinusOne,
  output logic tick
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;

  assign tick = (count_r >= divMinusOne);
  assign count_nxt = tick ? '0 : W'(count_r + 1'h1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  property p_div_by_one;
    @(posedge clk) disable iff (rst)
    (divMinusOne == '0) |-> tick;
  endproperty
  a_div_by_one: assert property (p_div_by_one) else $error("Prescaler of one must tick every cycle");

endmodule : cto_quantum_div

// [cto_line_driver.sv]
`timescale 1ns/100ps
module cto_line_driver import cto_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Line setting and value
  input cto_line_cfg_t cfg,
  input wire logic bitValue,
  input wire logic active,
  // Pin and transistor states
  output logic pinOut,
  output logic pinOeN,
  output logic pullupState,
  output logic pulldownState
);

  logic effValue;
  logic pullup_nxt;
  logic pulldown_nxt;
  logic pullup_r;
  logic pulldown_r;
  logic oeN_r;

  assign effValue = bitValue ^ cfg.polarity;
  assign pullup_nxt = active & cfg.highSideEn & effValue;
  assign pulldown_nxt = active & cfg.lowSideEn & ~effValue;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pullup_r <= 1'h0;
      pulldown_r <= 1'h0;
      oeN_r <= 1'h1;
    end else begin
      pullup_r <= pullup_nxt;
      pulldown_r <= pulldown_nxt;
      oeN_r <= ~(pullup_nxt | pulldown_nxt);
    end
  end

  assign pinOut = pullup_r;
  assign pinOeN = oeN_r;
  assign pullupState = pullup_r;
  assign pulldownState = pulldown_r;

  property p_pullup_cause;
    @(posedge clk) disable iff (rst)
    pullup_r |-> $past(cfg.highSideEn) && ($past(bitValue) ^ $past(cfg.polarity));
  endproperty
  a_pullup_cause: assert property (p_pullup_cause) else $error("Pull-up on without cause");

  property p_pulldown_cause;
    @(posedge clk) disable iff (rst)
    pulldown_r |-> $past(cfg.lowSideEn) && !($past(bitValue) ^ $past(cfg.polarity));
  endproperty
  a_pulldown_cause: assert property (p_pulldown_cause) else $error("Pull-down on without cause");

  property p_float_when_off;
    @(posedge clk) disable iff (rst)
    !active |=> pinOeN && !pullupState && !pulldownState;
  endproperty
  a_float_when_off: assert property (p_float_when_off) else $error("Line driven while inactive");

endmodule : cto_line_driver

// [cto_can_tx.sv]
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/100ps
// How it works
// - Mode 00 biphase, 01 unused, 10 data on both lines, 11 data plus bit clock.
// - Bit clock is high throughout the sync segment of every bit.
// - Internal bit is zero for dominant, one for recessive, before line settings.
// - Biphase toggle flips per dominant bit; first dominant bit goes on line A.
// - Biphase recessive bits switch every driver off on both lines.
// - Normal mode one shows each bit identically on both lines, never alternating.
// - Normal mode two puts bit clock on line B, high one quantum per bit.
// - Per-line high-side enable gates whether the pull-up may ever switch on.
// - Per-line low-side enable gates whether the pull-down may ever switch on.
// - Value xor polarity selects pull-up or pull-down if enabled, else line floats.
// - Identifier is 11 bits, eight high plus three low, sent MSB first.
// - Smallest identifier wins arbitration, as dominant zeros go out first.
// - Remote flag set sends a remote frame, clear sends a data frame.
// - Remote frames ignore the length code and carry no data bytes.
// - Length code is a binary byte count from 0 to 8.
// - Eight payload registers; only the counted ones are transmitted.
// - Drive config bits 7..0: B hs, ls, pol; A hs, ls, pol; mode.
// - Quantum is module clock divided by prescaler field plus one.
module cto_can_tx import cto_pkg::*; #(
  parameter int BIT_QUANTA = BIT_QUANTA_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Transmit lines, enable low while driven
  output logic lineOutA,
  output logic lineOutAOeN,
  output logic lineOutB,
  output logic lineOutBOeN,
  // Transistor states and internal bit
  output logic [1:0] pullupState,
  output logic [1:0] pulldownState,
  output logic txBitValue
);

  localparam int QW = $clog2(BIT_QUANTA + 1);
  localparam int CW = $clog2(FRAME_MAX_BITS + 1);

  // Bus decode
  logic [7:0] regIdx;
  logic reqValid;
  logic wrEn;
  logic wrCtrl;
  logic wrPrescale;
  logic wrDriveCfg;
  logic wrIdHigh;
  logic wrIdLow;
  logic wrPayload;
  logic [2:0] payloadSel;
  logic [7:0] wrByte;
  logic ack_r;
  logic [31:0] rdData_r;
  logic [7:0] rdByte;

  // Registers
  logic resetReq_r;
  logic [PRESCALE_W-1:0] prescale_r;
  cto_drive_cfg_t driveCfg_r;
  logic [7:0] idHigh_r;
  logic [7:0] idLowRtrLen_r;
  logic [7:0] payload_r [PAYLOAD_BYTES];

  // Transmit engine
  cto_tx_state_t txState_r;
  cto_tx_state_t txState_nxt;
  logic [FRAME_MAX_BITS-1:0] frameShift_r;
  logic [FRAME_MAX_BITS-1:0] frameLoad;
  logic [CW-1:0] bitsLeft_r;
  logic [CW-1:0] frameLen;
  logic [QW-1:0] qCnt_r;
  logic quantumTick;
  logic bitBoundary;
  logic startTx;
  logic busy;
  logic remoteFrame;
  logic [DLC_W-1:0] dlcField;
  logic [DLC_W-1:0] byteCount;
  logic [ID_W-1:0] frameId;
  logic txBit_r;
  logic syncPhase_r;
  logic toggle_r;

  // Line feed
  logic valA;
  logic valB;
  logic activeA;
  logic activeB;

  assign regIdx = wb_adr_i[9:2];
  assign reqValid = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wrEn = reqValid & wb_we_i & wb_sel_i[0];
  assign wrByte = wb_dat_i[7:0];
  assign busy = (txState_r == TX_SEND);
  // Timing and driver setup are frozen outside reset request
  assign wrCtrl = wrEn & (regIdx == IDX_CTRL);
  assign wrPrescale = wrEn & (regIdx == IDX_PRESCALE) & resetReq_r;
  assign wrDriveCfg = wrEn & (regIdx == IDX_DRIVE_CFG) & resetReq_r;
  // Buffer is locked while a frame is on the wire
  assign wrIdHigh = wrEn & (regIdx == IDX_ID_HIGH) & ~busy;
  assign wrIdLow = wrEn & (regIdx == IDX_ID_LOW) & ~busy;
  assign wrPayload = wrEn & ~busy & (regIdx >= IDX_PAYLOAD_FIRST) & (regIdx <= IDX_PAYLOAD_LAST);
  assign payloadSel = 3'(regIdx - IDX_PAYLOAD_FIRST);
  assign startTx = wrCtrl & wrByte[CTRL_TX_REQ_POS] & ~wrByte[CTRL_RESET_REQ_POS]
                   & ~resetReq_r & ~busy;

  // Read mux; unmapped words read zero and still acknowledge
  assign rdByte =
    (regIdx == IDX_CTRL) ? {5'h00, busy, 1'h0, resetReq_r} :
    (regIdx == IDX_PRESCALE) ? {2'h0, prescale_r} :
    (regIdx == IDX_DRIVE_CFG) ? driveCfg_r :
    (regIdx == IDX_ID_HIGH) ? idHigh_r :
    (regIdx == IDX_ID_LOW) ? idLowRtrLen_r :
    ((regIdx >= IDX_PAYLOAD_FIRST) && (regIdx <= IDX_PAYLOAD_LAST)) ? payload_r[payloadSel] :
    8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'h0;
      rdData_r <= '0;
    end else begin
      ack_r <= reqValid;
      rdData_r <= {24'h00_0000, rdByte};
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdData_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resetReq_r <= CTRL_RESET_REQ_RST;
      prescale_r <= '0;
      driveCfg_r <= REG_RST;
      idHigh_r <= REG_RST;
      idLowRtrLen_r <= REG_RST;
    end else begin
      if (wrCtrl) begin
        resetReq_r <= wrByte[CTRL_RESET_REQ_POS];
      end
      if (wrPrescale) begin
        prescale_r <= wrByte[PRESCALE_W-1:0];
      end
      if (wrDriveCfg) begin
        driveCfg_r <= wrByte;
      end
      if (wrIdHigh) begin
        idHigh_r <= wrByte;
      end
      if (wrIdLow) begin
        idLowRtrLen_r <= wrByte;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PAYLOAD_BYTES; i++) begin
        payload_r[i] <= REG_RST;
      end
    end else if (wrPayload) begin
      payload_r[payloadSel] <= wrByte;
    end
  end

  // Frame assembly
  assign frameId = {idHigh_r, idLowRtrLen_r[7:ID_LOW_POS]};
  assign remoteFrame = idLowRtrLen_r[RTR_POS];
  assign dlcField = idLowRtrLen_r[DLC_W-1:0];
  // Codes above eight still send eight bytes
  assign byteCount = remoteFrame ? 4'h0 :
                     (dlcField > DLC_MAX) ? DLC_MAX : dlcField;
  assign frameLen = CW'(FRAME_HDR_BITS) + CW'({byteCount, 3'h0});
  // Zero identifier bits are dominant, so lower values win the bus
  assign frameLoad = {1'h0, frameId, remoteFrame, 1'h0, 1'h0, dlcField,
                      payload_r[0], payload_r[1], payload_r[2], payload_r[3],
                      payload_r[4], payload_r[5], payload_r[6], payload_r[7]};

  cto_quantum_div #(
    .W(PRESCALE_W)
  ) u_quantum_div (
    .clk(clk),
    .rst(rst),
    .divMinusOne(prescale_r),
    .tick(quantumTick)
  );

  assign bitBoundary = quantumTick & (qCnt_r == QW'(BIT_QUANTA - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      qCnt_r <= '0;
      syncPhase_r <= 1'h0;
    end else if (quantumTick) begin
      qCnt_r <= bitBoundary ? '0 : QW'(qCnt_r + 1'h1);
      syncPhase_r <= bitBoundary;
    end
  end

  always_comb begin
    txState_nxt = txState_r;
    unique case (txState_r)
      TX_IDLE: begin
        if (startTx) begin
          txState_nxt = TX_SEND;
        end
      end
      TX_SEND: begin
        if (bitBoundary && (bitsLeft_r == '0)) begin
          txState_nxt = TX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txState_r <= TX_IDLE;
      frameShift_r <= '0;
      bitsLeft_r <= '0;
      txBit_r <= 1'h1;
      toggle_r <= 1'h0;
    end else begin
      txState_r <= txState_nxt;
      if (startTx) begin
        frameShift_r <= frameLoad;
        bitsLeft_r <= frameLen;
      end else if (bitBoundary) begin
        if (busy && (bitsLeft_r != '0)) begin
          txBit_r <= frameShift_r[FRAME_MAX_BITS-1];
          frameShift_r <= {frameShift_r[FRAME_MAX_BITS-2:0], 1'h1};
          bitsLeft_r <= CW'(bitsLeft_r - 1'h1);
        end else begin
          txBit_r <= 1'h1;
        end
        if (!txBit_r) begin
          toggle_r <= ~toggle_r;
        end
      end
    end
  end

  assign txBitValue = txBit_r;

  // Line coding per drive mode
  always_comb begin
    unique case (driveCfg_r.driveMode)
      MODE_BIPHASE: begin
        valA = 1'h0;
        valB = 1'h0;
        activeA = ~txBit_r & ~toggle_r;
        activeB = ~txBit_r & toggle_r;
      end
      MODE_NORMAL2: begin
        valA = txBit_r;
        valB = syncPhase_r;
        activeA = 1'h1;
        activeB = 1'h1;
      end
      // Unused code behaves as normal mode one
      default: begin
        valA = txBit_r;
        valB = txBit_r;
        activeA = 1'h1;
        activeB = 1'h1;
      end
    endcase
  end

  cto_line_driver u_line_a (
    .clk(clk),
    .rst(rst),
    .cfg(driveCfg_r.line0),
    .bitValue(valA),
    .active(activeA),
    .pinOut(lineOutA),
    .pinOeN(lineOutAOeN),
    .pullupState(pullupState[0]),
    .pulldownState(pulldownState[0])
  );

  cto_line_driver u_line_b (
    .clk(clk),
    .rst(rst),
    .cfg(driveCfg_r.line1),
    .bitValue(valB),
    .active(activeB),
    .pinOut(lineOutB),
    .pinOeN(lineOutBOeN),
    .pullupState(pullupState[1]),
    .pulldownState(pulldownState[1])
  );

  property p_biphase_recessive_float;
    @(posedge clk) disable iff (rst)
    (driveCfg_r.driveMode == MODE_BIPHASE) && txBit_r |=> lineOutAOeN && lineOutBOeN;
  endproperty
  a_biphase_recessive_float: assert property (p_biphase_recessive_float) else $error("Biphase recessive drives a line");

  property p_toggle_on_dominant;
    @(posedge clk) disable iff (rst)
    bitBoundary && !txBit_r |=> toggle_r != $past(toggle_r);
  endproperty
  a_toggle_on_dominant: assert property (p_toggle_on_dominant) else $error("Biphase toggle missed a dominant bit");

  property p_sync_one_quantum;
    @(posedge clk) disable iff (rst)
    $rose(syncPhase_r) && (prescale_r == '0) |=> !syncPhase_r;
  endproperty
  a_sync_one_quantum: assert property (p_sync_one_quantum) else $error("Bit clock high longer than one quantum");

  property p_normal1_same;
    @(posedge clk) disable iff (rst)
    (driveCfg_r.driveMode == MODE_NORMAL1) && (driveCfg_r.line0 == driveCfg_r.line1)
      && $stable(driveCfg_r) |=> (lineOutA == lineOutB) && (lineOutAOeN == lineOutBOeN);
  endproperty
  a_normal1_same: assert property (p_normal1_same) else $error("Normal mode one lines differ");

  property p_cfg_locked;
    @(posedge clk) disable iff (rst)
    !resetReq_r |=> $stable(driveCfg_r) && $stable(prescale_r);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked) else $error("Drive config changed outside reset request");

  property p_remote_no_data;
    @(posedge clk) disable iff (rst)
    startTx && remoteFrame |=> bitsLeft_r == CW'(FRAME_HDR_BITS);
  endproperty
  a_remote_no_data: assert property (p_remote_no_data) else $error("Remote frame carries data");

  property p_data_length;
    @(posedge clk) disable iff (rst)
    startTx && !remoteFrame && (dlcField <= DLC_MAX)
      |=> bitsLeft_r == CW'(FRAME_HDR_BITS) + CW'({$past(dlcField), 3'h0});
  endproperty
  a_data_length: assert property (p_data_length) else $error("Frame length mismatches length code");

  property p_id_first;
    @(posedge clk) disable iff (rst)
    startTx |=> frameShift_r[FRAME_MAX_BITS-2 -: ID_W] == {$past(idHigh_r), $past(idLowRtrLen_r[7:5])};
  endproperty
  a_id_first: assert property (p_id_first) else $error("Identifier not loaded MSB first");

  property p_idle_recessive;
    @(posedge clk) disable iff (rst)
    !busy && bitBoundary |=> txBit_r;
  endproperty
  a_idle_recessive: assert property (p_idle_recessive) else $error("Idle bit not recessive");

  property p_ack_single;
    @(posedge clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_single: assert property (p_ack_single) else $error("Acknowledge held two cycles");

endmodule : cto_can_tx

// [cto_bus_model.sv]
`timescale 1ns/100ps
module cto_bus_model (
  // Driver side
  input wire logic lineOutA,
  input wire logic lineOutAOeN,
  input wire logic lineOutB,
  input wire logic lineOutBOeN,
  // Resolved line levels
  output logic busA,
  output logic busB
);
  // Termination pulls a released line recessive, so a stale driven value never shows
  assign busA = lineOutAOeN ? 1'b1 : lineOutA;
  assign busB = lineOutBOeN ? 1'b1 : lineOutB;
endmodule : cto_bus_model

// [tb.sv]
`timescale 1ns/100ps
module tb;
  import cto_pkg::*;
  localparam int BQ = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic ack, outA, oenA, outB, oenB, txBit, busA, busB;
  logic [1:0] pu, pd;
  int failures = 0;
  int totalChecks = 0;
  logic [31:0] seed = 32'h0000_002E;
  logic [7:0] q;
  logic [7:0] pl [8];
  logic expBits[$];
  logic gotBits[$];

  always #50 clk = ~clk;

  cto_can_tx #(.BIT_QUANTA(BQ)) dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .lineOutA(outA), .lineOutAOeN(oenA), .lineOutB(outB),
    .lineOutBOeN(oenB), .pullupState(pu), .pulldownState(pd), .txBitValue(txBit));

  cto_bus_model bus (.lineOutA(outA), .lineOutAOeN(oenA), .lineOutB(outB),
    .lineOutBOeN(oenB), .busA(busA), .busB(busB));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Classic single cycle; the slave's answer time is never assumed
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'h1;
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat[7:0];
    if (n >= 50) failures++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    xfer(1'b0, idx, 8'h00);
    chk(q, e);
  endtask : rd

  function automatic int mkFrame(input logic [10:0] id, input logic rtr, input logic [3:0] dlc);
    int nb;
    logic [18:0] hdr;
    hdr = {1'b0, id, rtr, 2'b00, dlc};
    nb = rtr ? 0 : int'(dlc);
    expBits.delete();
    for (int i = 18; i >= 0; i--) expBits.push_back(hdr[i]);
    for (int b = 0; b < nb; b++)
      for (int i = 7; i >= 0; i--) expBits.push_back(pl[b][i]);
    return nb;
  endfunction : mkFrame

  task automatic load(input logic [7:0] cfg, input logic [5:0] ps, input logic [10:0] id,
                      input logic rtr, input logic [3:0] dlc);
    logic [31:0] r;
    xfer(1'b1, IDX_CTRL, 8'h01);
    xfer(1'b1, IDX_DRIVE_CFG, cfg);
    xfer(1'b1, IDX_PRESCALE, {2'b00, ps});
    xfer(1'b1, IDX_CTRL, 8'h00);
    xfer(1'b1, IDX_ID_HIGH, id[10:3]);
    xfer(1'b1, IDX_ID_LOW, {id[2:0], rtr, dlc});
    for (int i = 0; i < 8; i++) begin
      r = xs();
      pl[i] = r[7:0];
      xfer(1'b1, IDX_PAYLOAD_FIRST + 8'(i), pl[i]);
    end
    void'(mkFrame(id, rtr, dlc));
    xfer(1'b1, IDX_CTRL, 8'h02);
  endtask : load

  // Bit clock on line B marks each boundary; sample one quantum into the bit once it falls
  task automatic frameTest(input logic [10:0] id, input logic rtr, input logic [3:0] dlc);
    int hi, n, qc;
    logic prevB;
    logic [31:0] r;
    r = xs();
    qc = int'(r[1:0]) % 3 + 1;
    load(8'hDB, 6'(qc - 1), id, rtr, dlc);
    gotBits.delete();
    n = 0;
    prevB = busB;
    while (gotBits.size() < expBits.size() && n < 4000) begin
      @(negedge clk);
      n++;
      if (busB && !prevB) begin
        hi = 0;
        while (busB === 1'b1 && hi < 100) begin
          @(negedge clk);
          hi++;
        end
        chk(hi, qc);
        chk(busA, txBit);
        if (gotBits.size() > 0 || txBit === 1'b0) gotBits.push_back(txBit);
      end
      prevB = busB;
    end
    chk(gotBits.size(), expBits.size());
    for (int i = 0; i < gotBits.size(); i++) chk(gotBits[i], expBits[i]);
    // The next bit clock must open an idle bit with the engine already done
    n = 0;
    do begin
      prevB = busB;
      @(negedge clk);
      n++;
    end while (!(busB && !prevB) && n < 400);
    chk(txBit, 1'b1);
    rd(IDX_CTRL, 8'h00);
  endtask : frameTest

  // Fresh reset first so the toggle starts on line A
  task automatic biphaseTest();
    int act, zeros;
    logic txPrev, pa, pb;
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({oenA, oenB, txBit, pu, pd}, 32'h0000_0070);
    rd(IDX_CTRL, 8'h01);
    rd(IDX_DRIVE_CFG, 8'h00);
    load(8'hD8, 6'h00, 11'h000, 1'b0, 4'h1);
    zeros = 0;
    foreach (expBits[i]) zeros += int'(!expBits[i]);
    act = 0;
    txPrev = 1'b1;
    pa = 1'b1;
    pb = 1'b1;
    repeat ((expBits.size() + 4) * BQ) begin
      @(negedge clk);
      if (txPrev === 1'b1) chk({oenA, oenB}, 2'b11);
      if (!oenA && pa) begin
        chk(act % 2, 0);
        chk(outA, 1'b0);
        act++;
      end
      if (!oenB && pb) begin
        chk(act % 2, 1);
        act++;
      end
      pa = oenA;
      pb = oenB;
      txPrev = txBit;
    end
    chk(act, zeros);
  endtask : biphaseTest

  initial begin
    #6_000_000;
    failures++;
    report_and_stop();
  end

  initial begin
    logic [31:0] r;
    logic eff;
    logic [7:0] e;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(IDX_CTRL, 8'h01);
    for (int i = 8'h21; i < 8'h36; i++) rd(8'(i), 8'h00);
    for (int i = 8'h26; i <= 8'h33; i++) begin
      r = xs();
      e = (i == 8'h27 || i == 8'h29) ? 8'h00 : (i == 8'h26 ? r[7:0] & 8'h3F : r[7:0]);
      xfer(1'b1, 8'(i), r[7:0]);
      rd(8'(i), e);
    end
    // Idle line is recessive, so only the value-one half of the table shows here
    for (int c = 0; c < 8; c++) begin
      // Odd settings use the spare mode code, which must act as normal mode one
      xfer(1'b1, IDX_DRIVE_CFG, {3'(c), 3'(c), c[0] ? 2'b01 : 2'b10});
      @(negedge clk);
      @(negedge clk);
      eff = ~c[0];
      chk({pu, pd, oenA, outA}, {{2{c[2] & eff}}, {2{c[1] & ~eff}},
        ~((c[2] & eff) | (c[1] & ~eff)), c[2] & eff});
    end
    xfer(1'b1, IDX_CTRL, 8'h00);
    xfer(1'b1, IDX_DRIVE_CFG, 8'h5A);
    rd(IDX_DRIVE_CFG, 8'hFD);
    frameTest(11'h7FF, 1'b0, 4'h8);
    frameTest(11'h000, 1'b1, 4'h5);
    frameTest(11'h123, 1'b0, 4'h0);
    repeat (3) begin
      r = xs();
      frameTest(r[10:0], r[11], 4'(r[15:12] % 9));
    end
    biphaseTest();
    report_and_stop();
  end
endmodule : tb
